// ==== rtl/dsm_status_monitor.v ====
// Summary of operation
// (R1) Bits 15..8 of the collision register hold one peripheral write-collision flag per channel, channel 7 on top.
// (R2) Bits 7..0 of the collision register hold one RAM write-collision flag per channel, channel 7 on top.
// (R3) A collision flag reads 1 after a collision, resets to 0, and software can only clear it.
// (R4) Bits 11..8 of the second status word give the channel of the latest transfer, 0000 to 0111.
// (R5) That field reads 1111 from reset until the first transfer, and codes 1110..1000 never appear.
// (R6) Bits 7..0 of the second status word show each channel's selected buffer, 1 secondary, reset 0.
// (R7) Bits 15..12 of the second status word always read zero.
// (R8) A 16-bit read-only register resets to zero and holds the latest RAM address accessed.
// (R9) In ping-pong mode a channel alternates blocks between buffers, one per buffer in one-shot mode.
// (R10) Only the colliding channel's flag sets, a written 1 changes nothing, and it stays set until cleared.
`timescale 1ns/1ps
`default_nettype none
`include "dsm_defines.vh"
module dsm_status_monitor (
   input wire clk_i,
   input wire rst_i,
   // Classic Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output wire wb_err_o,
   // Channel events from the controller core (same clock)
   input wire [7:0] periph_coll_i,
   input wire [7:0] ram_coll_i,
   input wire xfer_valid_i,
   input wire [2:0] xfer_chan_i,
   input wire [15:0] xfer_ram_addr_i,
   input wire xfer_ram_access_i,
   input wire [7:0] block_done_i,
   // Buffer select and one-shot completion per channel; interrupt output
   output wire [7:0] pingpong_buffer_select_o,
   output wire [7:0] oneshot_done_o,
   output wire irq_o
);
   wire [7:0] pflag;
   wire [7:0] xflag;
   wire [7:0] pp_sel;
   wire [7:0] os_done;
   wire [7:0] clr_p;
   wire [7:0] clr_x;
   reg [3:0] last_ch_q;
   reg [15:0] ram_adr_q;
   reg [3:0] irq_stat_q;
   reg [3:0] irq_mask_q;
   reg [15:0] ppmode_q;
   reg [31:0] rd_d;
   wire req;
   wire wr_acc;
   wire mapped;
   wire [3:0] irq_ev;
   wire [3:0] irq_clr;

   // Single-cycle answer to each new request
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign mapped = (wb_adr_i == `DSM_ADDR_COLL) || (wb_adr_i == `DSM_ADDR_STAT1) ||
                   (wb_adr_i == `DSM_ADDR_RAMADR) || (wb_adr_i == `DSM_ADDR_IRQ_STAT) ||
                   (wb_adr_i == `DSM_ADDR_IRQ_MASK) || (wb_adr_i == `DSM_ADDR_PPMODE);
   assign wr_acc = req & wb_we_i & mapped;
   assign wb_err_o = 1'b0;

   // Write-zero-to-clear strobes, per byte lane; a written one leaves the flag alone
   // (R3) software can only clear
   assign clr_p = (wr_acc && wb_adr_i == `DSM_ADDR_COLL && wb_sel_i[1]) ?
                  ~wb_dat_i[`DSM_PERIPH_WRITE_COLLISION_FLAG_LSB +: 8] : 8'h00;
   assign clr_x = (wr_acc && wb_adr_i == `DSM_ADDR_COLL && wb_sel_i[0]) ?
                  ~wb_dat_i[`DSM_RAM_WRITE_COLLISION_FLAG_LSB +: 8] : 8'h00;

   // One state slice per channel
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_ch
         dsm_chan_state u_ch (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .periph_coll_i(periph_coll_i[g]),
            .ram_coll_i(ram_coll_i[g]),
            .clr_periph_i(clr_p[g]),
            .clr_ram_i(clr_x[g]),
            .block_done_i(block_done_i[g]),
            .pp_en_i(ppmode_q[2*g+1]),
            .oneshot_i(ppmode_q[2*g]),
            .periph_write_collision_flag_o(pflag[g]),
            .ram_write_collision_flag_o(xflag[g]),
            .pingpong_buffer_select_o(pp_sel[g]),
            .oneshot_done_o(os_done[g])
         );
      end
   endgenerate
   assign pingpong_buffer_select_o = pp_sel;
   assign oneshot_done_o = os_done;

   // Latest channel and RAM address
   // (R4) channel code of last transfer
   // (R5) 1111 until first transfer
   always @(posedge clk_i) begin
      if (rst_i) begin
         last_ch_q <= `DSM_LAST_ACTIVE_CHANNEL_NONE;
      end else if (xfer_valid_i) begin
         last_ch_q <= {1'b0, xfer_chan_i};
      end
   end

   // (R8) capture recent RAM address
   always @(posedge clk_i) begin
      if (rst_i) begin
         ram_adr_q <= `DSM_RAMADR_RST;
      end else if (xfer_ram_access_i) begin
         ram_adr_q <= xfer_ram_addr_i;
      end
   end

   // Interrupt events: any collision, any transfer, any block
   assign irq_ev = {|block_done_i, xfer_valid_i, |ram_coll_i, |periph_coll_i};
   assign irq_clr = (wr_acc && wb_adr_i == `DSM_ADDR_IRQ_STAT && wb_sel_i[0]) ?
                    wb_dat_i[3:0] : 4'h0;

   // Sticky status, set beats clear; mask and mode writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= 4'h0;
         irq_mask_q <= 4'h0;
         ppmode_q <= 16'h0000;
      end else begin
         irq_stat_q <= irq_ev | (irq_stat_q & ~irq_clr);
         if (wr_acc && wb_adr_i == `DSM_ADDR_IRQ_MASK && wb_sel_i[0])
            irq_mask_q <= wb_dat_i[3:0];
         if (wr_acc && wb_adr_i == `DSM_ADDR_PPMODE) begin
            if (wb_sel_i[0])
               ppmode_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               ppmode_q[15:8] <= wb_dat_i[15:8];
         end
      end
   end
   assign irq_o = |(irq_stat_q & irq_mask_q);

   // Read multiplexer
   always @* begin
      rd_d = 32'h00000000;
      case (wb_adr_i)
         // (R1) peripheral flags upper byte
         // (R2) RAM flags lower byte
         `DSM_ADDR_COLL: rd_d[15:0] = {pflag, xflag};
         // (R6) buffer select bits
         // (R7) top nibble reads zero
         `DSM_ADDR_STAT1: rd_d[15:0] = {4'h0, last_ch_q, pp_sel};
         `DSM_ADDR_RAMADR: rd_d[15:0] = ram_adr_q;
         `DSM_ADDR_IRQ_STAT: rd_d[3:0] = irq_stat_q;
         `DSM_ADDR_IRQ_MASK: rd_d[3:0] = irq_mask_q;
         `DSM_ADDR_PPMODE: rd_d[15:0] = ppmode_q;
         default: rd_d = 32'h00000000;
      endcase
   end

   // Ack one cycle after request; data registered
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i)
            wb_dat_o <= rd_d;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/dsm_defines.vh ====
`ifndef DSM_DEFINES_VH
`define DSM_DEFINES_VH
// Register byte offsets, one aligned word each
`define DSM_ADDR_COLL 8'h00
`define DSM_ADDR_STAT1 8'h04
`define DSM_ADDR_RAMADR 8'h08
`define DSM_ADDR_IRQ_STAT 8'h0c
`define DSM_ADDR_IRQ_MASK 8'h10
`define DSM_ADDR_PPMODE 8'h14
// Field positions
`define DSM_PERIPH_WRITE_COLLISION_FLAG_LSB 8
`define DSM_RAM_WRITE_COLLISION_FLAG_LSB 0
`define DSM_LAST_ACTIVE_CHANNEL_LSB 8
`define DSM_PINGPONG_BUFFER_SELECT_LSB 0
// Reset values
`define DSM_LAST_ACTIVE_CHANNEL_NONE 4'hf
`define DSM_COLL_RST 16'h0000
`define DSM_RAMADR_RST 16'h0000
`define DSM_PP_RST 8'h00
// Interrupt status bits
`define DSM_IRQ_PCOL 0
`define DSM_IRQ_XCOL 1
`define DSM_IRQ_XFER 2
`define DSM_IRQ_BLOCK 3
`define DSM_IRQ_W 4
`endif

// ==== rtl/dsm_chan_state.v ====
`timescale 1ns/1ps
`default_nettype none
// Per-channel collision flags and ping-pong buffer tracking
module dsm_chan_state (
   input wire clk_i,
   input wire rst_i,
   input wire periph_coll_i,
   input wire ram_coll_i,
   input wire clr_periph_i,
   input wire clr_ram_i,
   input wire block_done_i,
   input wire pp_en_i,
   input wire oneshot_i,
   output reg periph_write_collision_flag_o,
   output reg ram_write_collision_flag_o,
   output reg pingpong_buffer_select_o,
   output reg oneshot_done_o
);
   // Sticky flags: set wins over a software clear
   // (R3) clear-only sticky flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         periph_write_collision_flag_o <= 1'b0;
         ram_write_collision_flag_o <= 1'b0;
      end else begin
         // (R10) own channel only
         if (periph_coll_i)
            periph_write_collision_flag_o <= 1'b1;
         else if (clr_periph_i)
            periph_write_collision_flag_o <= 1'b0;
         if (ram_coll_i)
            ram_write_collision_flag_o <= 1'b1;
         else if (clr_ram_i)
            ram_write_collision_flag_o <= 1'b0;
      end
   end

   // Buffer select toggles per completed block
   // (R9) alternate primary and secondary
   always @(posedge clk_i) begin
      if (rst_i) begin
         pingpong_buffer_select_o <= 1'b0;
         oneshot_done_o <= 1'b0;
      end else if (!pp_en_i) begin
         pingpong_buffer_select_o <= 1'b0;
         oneshot_done_o <= 1'b0;
      end else if (block_done_i && !oneshot_done_o) begin
         pingpong_buffer_select_o <= ~pingpong_buffer_select_o;
         // One block per buffer in one-shot mode
         if (oneshot_i && pingpong_buffer_select_o)
            oneshot_done_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== tb/dsm_status_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsm_status_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [7:0] periph_coll_i,
   input wire logic [7:0] ram_coll_i,
   input wire logic xfer_valid_i,
   input wire logic [2:0] xfer_chan_i,
   input wire logic [15:0] xfer_ram_addr_i,
   input wire logic xfer_ram_access_i,
   input wire logic [7:0] block_done_i,
   input wire logic [7:0] pingpong_buffer_select_o
);
   logic rd_q;
   logic [7:0] ra_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Read request behind each ack
   always_ff @(posedge clk_i) begin
      rd_q <= wb_cyc_i && wb_stb_i && !wb_we_i;
      ra_q <= wb_adr_i;
   end
   AST_ST1_TOP: assert property (wb_ack_o && rd_q && ra_q == 8'h04 |-> wb_dat_o[15:12] == 4'h0)
      else $error("status1 top bits set");
   AST_LAST_ACTIVE_CHANNEL_CODE: assert property (wb_ack_o && rd_q && ra_q == 8'h04 |-> !wb_dat_o[11] || wb_dat_o[10:8] == 3'h7)
      else $error("reserved channel code");
   AST_LAST_ACTIVE_CHANNEL_VAL: assert property (wb_ack_o && rd_q && ra_q == 8'h04 && $past(xfer_valid_i, 2)
      |-> wb_dat_o[11:8] == {1'b0, $past(xfer_chan_i, 2)}) else $error("wrong last channel");
   AST_PCOL_RD: assert property (wb_ack_o && rd_q && ra_q == 8'h00
      |-> (wb_dat_o[15:8] & $past(periph_coll_i, 2)) == $past(periph_coll_i, 2)) else $error("periph flag lost");
   AST_XCOL_RD: assert property (wb_ack_o && rd_q && ra_q == 8'h00
      |-> (wb_dat_o[7:0] & $past(ram_coll_i, 2)) == $past(ram_coll_i, 2)) else $error("ram flag lost");
   AST_ADR_RD: assert property (wb_ack_o && rd_q && ra_q == 8'h08 && $past(xfer_ram_access_i, 2)
      |-> wb_dat_o[15:0] == $past(xfer_ram_addr_i, 2)) else $error("wrong ram address");
   AST_PP_RST: assert property ($fell(rst_i) |-> pingpong_buffer_select_o == 8'h00)
      else $error("select not reset");
   AST_PP_HOLD: assert property (pingpong_buffer_select_o != $past(pingpong_buffer_select_o)
      |-> $past(block_done_i) != 8'h00 || $past(wb_cyc_i && wb_we_i)) else $error("select moved alone");
endmodule
bind dsm_status_monitor dsm_status_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .periph_coll_i, .ram_coll_i, .xfer_valid_i, .xfer_chan_i, .xfer_ram_addr_i,
   .xfer_ram_access_i, .block_done_i, .pingpong_buffer_select_o);
`default_nettype wire

// ==== tb/dsm_chan_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsm_chan_model (
   input wire logic clk_i,
   output logic [7:0] pc_o,
   output logic [7:0] rc_o,
   output logic xv_o,
   output logic [2:0] xc_o,
   output logic [15:0] xa_o,
   output logic xr_o,
   output logic [7:0] bd_o
);
   // Quiet at time zero
   initial {pc_o, rc_o, xv_o, xc_o, xa_o, xr_o, bd_o} = '0;
   task automatic fire(input logic [3:0] k, input logic [2:0] ch, input logic [15:0] a);
      @(posedge clk_i);
      pc_o <= k[0] ? 8'h01 << ch : 8'h00;
      rc_o <= k[1] ? 8'h01 << ch : 8'h00;
      {xv_o, xr_o, xc_o, xa_o} <= {k[2], k[2], ch, a};
      bd_o <= k[3] ? 8'h01 << ch : 8'h00;
      @(posedge clk_i);
      {pc_o, rc_o, xv_o, xr_o, bd_o} <= '0;
      {xc_o, xa_o} <= {~ch, ~a}; // Stale lines flip
   endtask
endmodule
`default_nettype wire

// ==== tb/dsm_status_monitor_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsm_status_monitor_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0;
   wire [31:0] rd;
   wire ack, irq, xv, xr, err;
   wire [7:0] pc, rc, bd, pp, od;
   wire [2:0] xc;
   wire [15:0] xa;
   int n_fail = 0;
   int checks_done = 0;
   int ncyc = 0;
   logic [15:0] v;
   logic [15:0] e;
   initial forever #2.5 clk_i = ~clk_i;
   dsm_status_monitor dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'h3), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err), .periph_coll_i(pc),
      .ram_coll_i(rc), .xfer_valid_i(xv), .xfer_chan_i(xc), .xfer_ram_addr_i(xa), .xfer_ram_access_i(xr),
      .block_done_i(bd), .pingpong_buffer_select_o(pp), .oneshot_done_o(od), .irq_o(irq));
   dsm_chan_model mdl_u (.clk_i, .pc_o(pc), .rc_o(rc), .xv_o(xv), .xc_o(xc), .xa_o(xa), .xr_o(xr), .bd_o(bd));
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // Classic single cycle; q takes read data at the ack edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_i);
      {cyc, we, adr, wd} <= {1'b1, w, a, 16'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rd[15:0];
      cyc <= 1'b0;
   endtask
   task automatic t_reset;
      bus(0, 8'h00, 0, v); chk("coll", 16'h0000, v);
      bus(0, 8'h04, 0, v); chk("stat1", 16'h0f00, v);
      bus(0, 8'h08, 0, v); chk("ramadr", 16'h0000, v);
      bus(0, 8'h3c, 0, v); chk("unmapped", 16'h0000, v);
      chk("irq", 0, irq);
      chk("err", 0, err);
   endtask
   task automatic t_coll;
      for (int c = 0; c < 8; c++) begin
         mdl_u.fire(4'h3 - (c == 3), c[2:0], 16'h0);
         mdl_u.fire(4'h2, 3'(7 - c), 16'h0);
         e = (c == 3 ? 16'h0000 : 16'h0100 << c) | (16'h0001 << (7 - c)) | (16'h0001 << c);
         bus(1, 8'h00, 16'hffff, v); bus(0, 8'h00, 0, v); chk("coll set", e, v);
         bus(1, 8'h00, 16'h0000, v); bus(0, 8'h00, 0, v); chk("coll clr", 16'h0000, v);
      end
   endtask
   task automatic t_xfer;
      for (int c = 0; c < 8; c++) begin
         mdl_u.fire(4'h4, c[2:0], 16'h8000 | 16'(c * 37));
         bus(0, 8'h04, 0, v); chk("last ch", {5'h0, c[2:0], 8'h00}, v);
         bus(0, 8'h08, 0, v); chk("ram adr", 16'h8000 | 16'(c * 37), v);
      end
   endtask
   task automatic t_pp;
      bus(1, 8'h14, 16'h0002, v);
      for (int i = 0; i < 5; i++) begin
         if (i == 2) bus(1, 8'h14, 16'h0003, v);
         mdl_u.fire(4'h8, 3'h0, 16'h0);
         bus(0, 8'h04, 0, v); chk("select", {8'h07, 7'h0, i == 0 || i == 2}, v);
      end
      chk("oneshot", 16'h0001, {8'h0, od});
   endtask
   task automatic t_irq;
      bus(1, 8'h0c, 16'h000f, v);
      bus(1, 8'h10, 16'h0002, v);
      mdl_u.fire(4'h2, 3'h5, 16'h0);
      bus(0, 8'h0c, 0, v); chk("irq stat", 16'h0002, v);
      chk("irq on", 1, irq);
      bus(1, 8'h10, 16'h0000, v); chk("irq masked", 0, irq);
      bus(1, 8'h10, 16'h0002, v); chk("irq again", 1, irq);
      bus(1, 8'h0c, 16'h0002, v); chk("irq clr", 0, irq);
   endtask
   // Cut a hang short
   always @(posedge clk_i) begin
      ncyc <= ncyc + 1;
      if (ncyc == 4000) begin
         n_fail++;
         end_of_test;
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_coll;
      t_xfer;
      t_pp;
      t_irq;
      end_of_test;
   end
endmodule
`default_nettype wire
